//--- core/ise_pkg.sv
// ****************************************
// shared constants
// ****************************************
package ise_pkg;
  localparam int          DATA_W      = 8;
  localparam int          PC_W        = 11;
  localparam int          INSN_W      = 12;
  // pc bit forced low by pc writers other than the jump
  localparam int          PC_FORCE_BIT = 8;
  // file addresses
  localparam logic [4:0]  ADDR_PCL    = 5'h02;
  localparam logic [4:0]  ADDR_TIMER  = 5'h01;
  localparam logic [4:0]  ADDR_PORT_A = 5'h05;
  localparam logic [4:0]  ADDR_PORT_B = 5'h06;
  localparam logic [4:0]  ADDR_PORT_C = 5'h07;
  // reset value of direction latches: all inputs
  localparam logic [7:0]  DIR_RST     = 8'hff;
  // opcode patterns
  localparam logic [11:0] OP_DIR_LOAD = 12'h000;
  localparam logic [2:0]  OP_JUMP     = 3'h5;
  localparam logic [3:0]  OP_CALL     = 4'h9;
  localparam logic [3:0]  OP_RET_LIT  = 4'h8;
  localparam logic [1:0]  OP_FILE_GRP = 2'h0;
  localparam logic [2:0]  OP_BIT_WR   = 3'h2;
  // destination bit of the byte group
  localparam int          D_BIT       = 5;
  // ports that own a direction latch
  localparam int          NUM_PORTS   = 3;
endpackage : ise_pkg

//--- core/ise_core.sv
`timescale 1ns/1ps
`default_nettype none
module ise_core #(
  // pc width follows the program memory; the data path stays eight bits,
  // fixed by the literal field of the instruction word
  parameter int PC_W = ise_pkg::PC_W
) (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  // decoded instruction stream
  input  wire logic                  insn_valid_i,
  input  wire logic [11:0]           insn_i,
  input  wire logic [7:0]            w_i,
  input  wire logic [7:0]            alu_result_i,
  input  wire logic [PC_W-1:0]       pc_target_i,
  input  wire logic [PC_W-1:0]       stack_top_entry_i,
  input  wire logic                  presc_to_timer_i,
  // port pins and data latches
  input  wire logic [7:0]            pin_a_i,
  input  wire logic [7:0]            pin_b_i,
  input  wire logic [7:0]            pin_c_i,
  input  wire logic [7:0]            first_port_data_i,
  input  wire logic [7:0]            second_port_data_i,
  input  wire logic [7:0]            third_port_data_i,
  // results
  output logic [7:0]                 operand_o,
  output logic                       pc_load_o,
  output logic [PC_W-1:0]            pc_next_o,
  output logic                       w_load_o,
  output logic [7:0]                 w_next_o,
  output logic                       presc_clr_o,
  output logic                       busy_o,
  output logic [7:0]                 dir_a_o,
  output logic [7:0]                 dir_b_o,
  output logic [7:0]                 dir_c_o,
  output logic [7:0]                 oe_a_o,
  output logic [7:0]                 oe_b_o,
  output logic [7:0]                 oe_c_o
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the forced page bit must exist inside the pc
  if (PC_W <= ise_pkg::PC_FORCE_BIT) begin : g_bad_pc_w
    $error("ise_core: PC_W too narrow for the forced pc bit");
  end
  // the direction slices assume the port addresses follow one another
  if (ise_pkg::ADDR_PORT_C != ise_pkg::ADDR_PORT_A + 5'(ise_pkg::NUM_PORTS - 1)) begin : g_bad_port_map
    $error("ise_core: port addresses are not consecutive");
  end

  // keep-mask that clears the forced bit on every pc writer but the jump
  localparam logic [PC_W-1:0] PC_KEEP = ~(PC_W'(1) << ise_pkg::PC_FORCE_BIT);

  // ****************************************
  // decode
  // ****************************************
  logic [4:0] faddr;
  logic       is_file_op;
  logic       is_bit_wr;
  logic       writes_file;
  logic       is_jump;
  logic       is_call;
  logic       is_ret;
  logic       is_dir;
  logic       pc_file_wr;

  assign faddr       = insn_i[4:0];
  assign is_file_op  = insn_i[11:10] == ise_pkg::OP_FILE_GRP;
  assign is_bit_wr   = insn_i[11:9] == ise_pkg::OP_BIT_WR;
  // every byte-group writer of f has bit 5 set, move-to-file and clear included;
  // bit set/clear always write back, bit tests never do
  assign writes_file = (is_file_op && insn_i[ise_pkg::D_BIT]) || is_bit_wr;
  assign is_jump     = insn_i[11:9] == ise_pkg::OP_JUMP;
  assign is_call     = insn_i[11:8] == ise_pkg::OP_CALL;
  assign is_ret      = insn_i[11:8] == ise_pkg::OP_RET_LIT;
  assign is_dir      = insn_i[11:3] == ise_pkg::OP_DIR_LOAD[11:3];
  assign pc_file_wr  = writes_file && (faddr == ise_pkg::ADDR_PCL);

  // ****************************************
  // source operand for port registers
  // ****************************************
  logic [7:0] next_operand;
  always_comb begin
    unique case (faddr)
      ise_pkg::ADDR_PORT_A: next_operand = pin_a_i;
      ise_pkg::ADDR_PORT_B: next_operand = pin_b_i;
      ise_pkg::ADDR_PORT_C: next_operand = pin_c_i;
      default:              next_operand = 8'h00;
    endcase
  end

  // pin level replaces latch so a low-driven input writes back zero
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      operand_o <= 8'h00;
    end else begin
      operand_o <= next_operand;
    end
  end

  // ****************************************
  // return-with-literal two-cycle sequencer
  // ****************************************
  typedef enum logic [0:0] {
    ISE_IDLE = 1'b0,
    ISE_RET2 = 1'b1
  } ise_state_t;
  ise_state_t state;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ISE_IDLE;
    end else begin
      unique case (state)
        ISE_IDLE: if (insn_valid_i && is_ret) state <= ISE_RET2;
        ISE_RET2: state <= ISE_IDLE;
      endcase
    end
  end

  // second cycle is a flush; issue ignored while busy
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state == ISE_IDLE) && insn_valid_i && is_ret;
    end
  end

  // ****************************************
  // program counter and w
  // ****************************************
  logic take;
  assign take = insn_valid_i && (state == ISE_IDLE);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_load_o <= 1'b0;
      pc_next_o <= '0;
    end else begin
      pc_load_o <= take && (is_jump || is_call || is_ret || pc_file_wr);
      if (take && is_jump) begin
        pc_next_o <= pc_target_i; // jump keeps its full target
      end else if (take && is_ret) begin
        pc_next_o <= stack_top_entry_i & PC_KEEP;
      end else if (take && is_call) begin
        pc_next_o <= pc_target_i & PC_KEEP;
      end else if (take && pc_file_wr) begin
        pc_next_o <= pc_target_i & PC_KEEP;
      end
    end
  end

  // flags untouched: no status output on this path
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      w_load_o <= 1'b0;
      w_next_o <= 8'h00;
    end else begin
      w_load_o <= take && is_ret;
      if (take && is_ret) begin
        w_next_o <= insn_i[7:0];
      end
    end
  end

  // ****************************************
  // prescaler clear
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      presc_clr_o <= 1'b0;
    end else begin
      presc_clr_o <= take && writes_file && (faddr == ise_pkg::ADDR_TIMER) && presc_to_timer_i;
    end
  end

  // ****************************************
  // direction latches and drivers
  // ****************************************
  // one slice per port; w lands in the latch named by the operand
  for (genvar p = 0; p < ise_pkg::NUM_PORTS; p++) begin : g_port
    logic       hit;
    logic [7:0] next_dir;
    logic [7:0] dir;
    logic [7:0] oe;
    assign hit      = take && is_dir && (faddr == ise_pkg::ADDR_PORT_A + 5'(p));
    assign next_dir = hit ? w_i : dir;

    // enable registered beside its latch so both outputs stay flop-driven;
    // reset leaves every pin an input until software loads a direction
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        dir <= ise_pkg::DIR_RST;
        oe  <= ~ise_pkg::DIR_RST;
      end else begin
        dir <= next_dir;
        oe  <= ~next_dir;
      end
    end
  end

  assign dir_a_o = g_port[0].dir;
  assign dir_b_o = g_port[1].dir;
  assign dir_c_o = g_port[2].dir;
  assign oe_a_o  = g_port[0].oe;
  assign oe_b_o  = g_port[1].oe;
  assign oe_c_o  = g_port[2].oe;

endmodule : ise_core
`default_nettype wire

//--- testbench/ise_core_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// core port checks
// ****************
module ise_chk (
  // inputs
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic        insn_valid_i,
  input wire logic [11:0] insn_i,
  input wire logic [7:0]  w_i,
  input wire logic [10:0] pc_target_i,
  input wire logic [10:0] stack_top_entry_i,
  input wire logic        presc_to_timer_i,
  input wire logic [7:0]  pin_a_i,
  // outputs
  input wire logic [7:0]  operand_o,
  input wire logic        pc_load_o,
  input wire logic [10:0] pc_next_o,
  input wire logic        w_load_o,
  input wire logic [7:0]  w_next_o,
  input wire logic        presc_clr_o,
  input wire logic        busy_o,
  input wire logic [7:0]  dir_a_o,
  input wire logic [7:0]  oe_a_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // issue in the busy cycle is dropped, so it never counts as taken
  wire logic tk = insn_valid_i && !busy_o;
  sequence s_ret; tk && insn_i[11:8] == 4'h8; endsequence
  a_ret_pc_top: assert property (s_ret |=> pc_load_o && pc_next_o == ($past(stack_top_entry_i) & 11'h6ff))
    else $error("return pc not stack top with bit 8 low");
  a_ret_w_lit: assert property (s_ret |=> w_load_o && w_next_o == $past(insn_i[7:0]))
    else $error("return literal not loaded");
  a_ret_two_cyc: assert property (s_ret |=> busy_o ##1 !busy_o)
    else $error("return busy not one extra cycle");
  a_jump_keeps_pc: assert property (tk && insn_i[11:9] == 3'h5 |=> pc_load_o && pc_next_o == $past(pc_target_i))
    else $error("jump target altered");
  a_call_clears_bit: assert property (tk && insn_i[11:8] == 4'h9 |=> pc_load_o && !pc_next_o[8])
    else $error("call left pc bit 8 set");
  a_dir_a_load: assert property (tk && insn_i == 12'h005 |=> dir_a_o == $past(w_i))
    else $error("direction latch a not loaded from w");
  a_oe_follows_dir: assert property (oe_a_o == ~dir_a_o)
    else $error("driver enable not inverse of direction");
  a_timer_presc_clr: assert property (tk && insn_i == 12'h021 && presc_to_timer_i |=> presc_clr_o)
    else $error("prescaler not cleared on timer write");
  a_pin_operand: assert property (tk && insn_i[11:10] == 2'h0 && insn_i[4:0] == 5'h05 |=> operand_o == $past(pin_a_i))
    else $error("port operand not taken from pins");
  a_bit_wr_presc: assert property (tk && insn_i[11:9] == 3'h2 && insn_i[4:0] == 5'h01 && presc_to_timer_i |=> presc_clr_o)
    else $error("prescaler not cleared on timer bit write");
  a_presc_needs_timer: assert property (!presc_to_timer_i |=> !presc_clr_o)
    else $error("prescaler cleared while not assigned to timer");
endmodule : ise_chk
bind ise_core ise_chk u_chk (
  .core_clk_i        (core_clk_i),
  .rstn_i            (rstn_i),
  .insn_valid_i      (insn_valid_i),
  .insn_i            (insn_i),
  .w_i               (w_i),
  .pc_target_i       (pc_target_i),
  .stack_top_entry_i (stack_top_entry_i),
  .presc_to_timer_i  (presc_to_timer_i),
  .pin_a_i           (pin_a_i),
  .operand_o         (operand_o),
  .pc_load_o         (pc_load_o),
  .pc_next_o         (pc_next_o),
  .w_load_o          (w_load_o),
  .w_next_o          (w_next_o),
  .presc_clr_o       (presc_clr_o),
  .busy_o            (busy_o),
  .dir_a_o           (dir_a_o),
  .oe_a_o            (oe_a_o)
);
`default_nettype wire

//--- testbench/tb_instruction_side_effects.sv
`timescale 1ns/1ps
`default_nettype none
// *****************
// random issue bench
// *****************
module tb_instruction_side_effects;
  logic        clk = 1'b0, rstn = 1'b0, vld = 1'b0, pre = 1'b0, t, wr, epl, ewl, ecl, eb;
  logic [11:0] ins = 12'h000;
  logic [10:0] tgt = 11'h000, stack_top_entry = 11'h000, epc;
  logic [7:0]  w = 8'h00, alu = 8'h00, pa = 8'h00, pb = 8'h00, pcn = 8'h00, da = 8'h00, db = 8'h00, dc = 8'h00;
  logic [7:0]  ew, eop, edir[3];
  wire  [7:0]  op, wn, dra, drb, drc, oea, oeb, oec;
  wire  [10:0] pn;
  wire         pl, wl, cl, bz;
  int          err_total = 0, cmp_count = 0, i, k;
  // return, jump, call, direction load, timer write, pcl write, bit ops, port ops, anything
  logic [11:0] pat[9] = '{12'h800, 12'ha00, 12'h900, 12'h004, 12'h021, 12'h022, 12'h405, 12'h204, 12'h000};
  logic [11:0] msk[9] = '{12'h0ff, 12'h1ff, 12'h0ff, 12'h003, 12'h460, 12'h7c0, 12'h1e0, 12'h3e3, 12'hfff};
  always #10 clk = ~clk;
  ise_core dut (.core_clk_i(clk), .rstn_i(rstn), .insn_valid_i(vld), .insn_i(ins), .w_i(w),
    .alu_result_i(alu), .pc_target_i(tgt), .stack_top_entry_i(stack_top_entry), .presc_to_timer_i(pre),
    .pin_a_i(pa), .pin_b_i(pb), .pin_c_i(pcn), .first_port_data_i(da), .second_port_data_i(db),
    .third_port_data_i(dc), .operand_o(op), .pc_load_o(pl), .pc_next_o(pn), .w_load_o(wl),
    .w_next_o(wn), .presc_clr_o(cl), .busy_o(bz), .dir_a_o(dra), .dir_b_o(drb), .dir_c_o(drc),
    .oe_a_o(oea), .oe_b_o(oeb), .oe_c_o(oec));
  task chk(input string n, input logic [23:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task mreset();
    {epl, ewl, ecl, eb, epc, ew} = '0;
    edir = '{8'hff, 8'hff, 8'hff};
  endtask : mreset
  task run(input int n);
    for (i = 0; i < n; i++) begin
      k = $urandom % 9;
      vld = ($urandom % 8) != 0;
      ins = pat[k] | (msk[k] & 12'($urandom));
      {w, alu, pa, pb, pcn, da, db, dc} = {$urandom, $urandom};
      {tgt, stack_top_entry, pre} = 23'($urandom);
      @(negedge clk);
      // model of the edge just passed
      t = vld && !eb;
      wr = ins[11:10] == 2'h0 && ins[5] || ins[11:9] == 3'h2;
      {epl, ewl, ecl, eb} = '0;
      if (t && ins[11:8] == 4'h8) {epl, ewl, eb, epc, ew} = {3'h7, stack_top_entry & 11'h6ff, ins[7:0]};
      if (t && ins[11:9] == 3'h5) {epl, epc} = {1'b1, tgt};
      if (t && (ins[11:8] == 4'h9 || wr && ins[4:0] == 5'h02)) {epl, epc} = {1'b1, tgt & 11'h6ff};
      ecl = t && wr && ins[4:0] == 5'h01 && pre;
      if (t && ins[11:3] == 9'h000 && ins[2:0] > 3'h4) edir[ins[2:0] - 3'h5] = w;
      eop = ins[4:0] == 5'h05 ? pa : ins[4:0] == 5'h06 ? pb : ins[4:0] == 5'h07 ? pcn : 8'h00;
      chk("pulses", {pl, wl, bz}, {epl, ewl, eb});
      chk("pc_next", pn, epc);
      chk("w_next", wn, ew);
      chk("presc_clr", cl, ecl);
      chk("dir", {dra, drb, drc}, {edir[0], edir[1], edir[2]});
      chk("oe", {oea, oeb, oec}, ~{edir[0], edir[1], edir[2]});
      if (t && ins[11:10] == 2'h0) chk("operand", op, eop);
    end
  endtask : run
  task end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    mreset();
    k = $urandom(84);
    repeat (5) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    run(600);
    $display("test random issue done");
    // reset in mid-run must bring every port back to all inputs
    rstn = 1'b0;
    #1;
    mreset();
    chk("rst_dir", {dra, drb, drc}, 24'hffffff);
    chk("rst_pc", {pl, bz, pn}, 24'h000000);
    @(negedge clk) rstn = 1'b1;
    run(300);
    $display("test reset and reissue done");
    end_of_test();
  end
  // whole run is about 900 cycles of 20 ns
  initial begin
    #40us;
    err_total++;
    end_of_test();
  end
endmodule : tb_instruction_side_effects
`default_nettype wire
